// [core/lmm_mode_select.sv]
module lmm_mode_select
    import lmm_pkg::*;
(
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    input  wire logic [AXI_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [AXI_AW-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              tx_data_i,
    input  wire logic              rts_req_i,
    input  wire logic              dtr_req_i,
    input  wire logic              line_rx_data_i,
    input  wire logic              clear_to_send_i,
    input  wire logic              modem_tx_clk_i,
    input  wire logic              modem_rx_clk_i,
    input  wire logic              integ_clk_i,
    input  wire logic              variant_integral_i,
    output lmm_line_t              line_o
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [NUM_PINS-1:0] pin_raw;
    logic [NUM_PINS-1:0] pin_lvl;
    logic [NUM_PINS-1:0] pin_rise;

    assign pin_raw = {variant_integral_i, integ_clk_i, modem_rx_clk_i,
                      modem_tx_clk_i, clear_to_send_i, line_rx_data_i};

    lmm_pin_sync #(.W(NUM_PINS)) u_sync (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .pin_i     (pin_raw),
        .level_o   (pin_lvl),
        .rise_o    (pin_rise)
    );

    // ------------------------------------------------------------
    // Register bus slave state
    // ------------------------------------------------------------
    logic              aw_held, next_aw_held;
    logic [AXI_AW-1:0] aw_addr, next_aw_addr;
    logic              w_held, next_w_held;
    logic [31:0]       w_data, next_w_data;
    logic [3:0]        w_strb, next_w_strb;
    logic              next_awready, next_wready;
    logic              next_bvalid, next_arready, next_rvalid;
    logic [1:0]        next_bresp, next_rresp;
    logic [31:0]       next_rdata;
    logic [1:0]        ctrl, next_ctrl;
    logic              step_pulse, next_step;
    logic [DIV_W-1:0]  int_cnt, next_int_cnt;
    logic              int_clk, next_int_clk;
    logic              int_tick, next_int_tick;
    logic              do_write;
    logic [31:0]       status_word;
    lmm_mode_t         mode;

    // Software view of the block's own state
    always_comb begin
        status_word = '0;
        status_word[STAT_MODE_LSB +: 2] = mode;
        status_word[STAT_SEND_BIT]      = line_o.send_enable;
        status_word[STAT_RTS_BIT]       = line_o.rts;
        status_word[STAT_DTR_BIT]       = line_o.dtr;
        status_word[STAT_VAR_BIT]       = pin_lvl[PIN_VARIANT];
        status_word[STAT_ICLK_BIT]      = int_clk;
    end

    // Write and read channels; address and data taken in either order
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held  = w_held;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_ctrl    = ctrl;
        next_step    = 1'b0;
        do_write     = aw_held && w_held && !s_axi_bvalid;
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = RESP_OKAY;
            if (aw_addr[AXI_AW-1:2] == ADDR_CTRL[AXI_AW-1:2]) begin
                if (w_strb[0]) begin
                    next_ctrl = w_data[CTRL_RUN_BIT:CTRL_LOOP_BIT];
                end
            end else if (aw_addr[AXI_AW-1:2] == ADDR_STEP[AXI_AW-1:2]) begin
                next_step = w_strb[0] && w_data[STEP_BIT];
            end else if (aw_addr[AXI_AW-1:2] !=
                         ADDR_STATUS[AXI_AW-1:2]) begin
                next_bresp = RESP_SLVERR;
            end
        end
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        next_awready = !next_aw_held;
        next_wready  = !next_w_held;
        // Read side: one read in flight, answered the next cycle
        next_arready = s_axi_arready;
        next_rvalid  = s_axi_rvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid  = 1'b0;
            next_arready = 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_arready = 1'b0;
            next_rvalid  = 1'b1;
            next_rresp   = RESP_OKAY;
            next_rdata   = '0;
            if (s_axi_araddr[AXI_AW-1:2] == ADDR_CTRL[AXI_AW-1:2]) begin
                next_rdata[1:0] = ctrl;
            end else if (s_axi_araddr[AXI_AW-1:2] ==
                         ADDR_STATUS[AXI_AW-1:2]) begin
                next_rdata = status_word;
            end else if (s_axi_araddr[AXI_AW-1:2] !=
                         ADDR_STEP[AXI_AW-1:2]) begin
                next_rresp = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            aw_held       <= 1'b0;
            aw_addr       <= '0;
            w_held        <= 1'b0;
            w_data        <= '0;
            w_strb        <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
            ctrl          <= CTRL_RESET;
            step_pulse    <= 1'b0;
        end else begin
            aw_held       <= next_aw_held;
            aw_addr       <= next_aw_addr;
            w_held        <= next_w_held;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
            ctrl          <= next_ctrl;
            step_pulse    <= next_step;
        end
    end

    // ------------------------------------------------------------
    // Internal 10 KHz test clock, divided from the system clock
    // ------------------------------------------------------------
    // Tick marks each rising edge of the divided clock
    always_comb begin
        next_int_cnt  = int_cnt + 1'b1;
        next_int_clk  = int_clk;
        next_int_tick = 1'b0;
        if (int_cnt == DIV_LAST) begin
            next_int_cnt  = '0;
            next_int_clk  = !int_clk;
            next_int_tick = !int_clk;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            int_cnt  <= '0;
            int_clk  <= 1'b0;
            int_tick <= 1'b0;
        end else begin
            int_cnt  <= next_int_cnt;
            int_clk  <= next_int_clk;
            int_tick <= next_int_tick;
        end
    end

    // ------------------------------------------------------------
    // Mode multiplexers
    // ------------------------------------------------------------
    lmm_line_t next_line;
    logic      loop_mode;
    logic      integral;

    assign integral = pin_lvl[PIN_VARIANT];

    assign mode      = lmm_decode_mode(ctrl[CTRL_LOOP_BIT],
                                       ctrl[CTRL_RUN_BIT]);
    assign loop_mode = (mode == LMM_INT_MAINT) || (mode == LMM_SYS_TEST);

    always_comb begin
        next_line = '0;
        next_line.send_enable = loop_mode ? 1'b1 : pin_lvl[PIN_CTS];
        next_line.rx_data = loop_mode ? tx_data_i : pin_lvl[PIN_LINE_RX];
        next_line.rts = !loop_mode && rts_req_i;
        next_line.dtr = !loop_mode && dtr_req_i;
        unique case (mode)
            LMM_INT_MAINT: begin
                next_line.tx_bit_en = step_pulse;
                next_line.rx_bit_en = step_pulse;
            end
            LMM_SYS_TEST: begin
                next_line.tx_bit_en = int_tick;
                next_line.rx_bit_en = int_tick;
            end
            LMM_EXT_MAINT: begin
                next_line.ext_clk = !integral && int_clk;
                next_line.tx_bit_en = integral ? pin_rise[PIN_INTEG_CLK]
                                               : pin_rise[PIN_MTX_CLK];
                next_line.rx_bit_en = integral ? pin_rise[PIN_INTEG_CLK]
                                               : pin_rise[PIN_MRX_CLK];
            end
            LMM_NORMAL: begin
                next_line.tx_bit_en = integral ? pin_rise[PIN_INTEG_CLK]
                                               : pin_rise[PIN_MTX_CLK];
                next_line.rx_bit_en = integral ? pin_rise[PIN_INTEG_CLK]
                                               : pin_rise[PIN_MRX_CLK];
            end
        endcase
    end

    // Outputs registered so the modem sees no mux glitches
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            line_o <= '0;
        end else begin
            line_o <= next_line;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_send_forced;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        loop_mode |=> line_o.send_enable;
    endproperty
    a_send_forced: assert property (p_send_forced)
        else $error("send enable not forced in loop mode");

    property p_loop_data;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        loop_mode |=> (line_o.rx_data == $past(tx_data_i));
    endproperty
    a_loop_data: assert property (p_loop_data)
        else $error("receive data not looped from transmit");

    property p_hs_off;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        loop_mode |=> (!line_o.rts && !line_o.dtr);
    endproperty
    a_hs_off: assert property (p_hs_off)
        else $error("handshake output active in loop mode");

    property p_step_clk;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (mode == LMM_INT_MAINT) |=>
            (line_o.tx_bit_en == $past(step_pulse)) &&
            (line_o.rx_bit_en == $past(step_pulse));
    endproperty
    a_step_clk: assert property (p_step_clk)
        else $error("bit clock does not follow step pulse");

    property p_sys_clk;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (mode == LMM_SYS_TEST) |=> (line_o.tx_bit_en == $past(int_tick));
    endproperty
    a_sys_clk: assert property (p_sys_clk)
        else $error("system test bit clock not internal clock");

    property p_ext_drive;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (mode == LMM_EXT_MAINT && !integral) |=>
            (line_o.ext_clk == $past(int_clk));
    endproperty
    a_ext_drive: assert property (p_ext_drive)
        else $error("internal clock not driven out");

    property p_integ_clk;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (mode == LMM_EXT_MAINT && integral && pin_rise[PIN_INTEG_CLK])
            |=> (line_o.tx_bit_en && line_o.rx_bit_en && !line_o.ext_clk);
    endproperty
    a_integ_clk: assert property (p_integ_clk)
        else $error("integral modem clock not used");

    // Release edge excluded: outputs still hold reset values one cycle on
    property p_normal;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        rst_n_i && (mode == LMM_NORMAL) |=>
            (line_o.rts == $past(rts_req_i)) &&
            (line_o.rx_data == $past(pin_lvl[PIN_LINE_RX])) &&
            !line_o.ext_clk;
    endproperty
    a_normal: assert property (p_normal)
        else $error("normal mode path wrong");

    property p_tick_period;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        int_tick |=> !int_tick [*8];
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("internal clock ticks too close");

endmodule

// [core/lmm_pin_sync.sv]
module lmm_pin_sync
    import lmm_pkg::*;
#(
    parameter int W = NUM_PINS
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o,
    output logic      [W-1:0] rise_o
);

    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] last;
    logic [W-1:0] next_rise;

    // ------------------------------------------------------------
    // Edge detection reads only the second and third stages
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < W; i++) begin
            next_rise[i] = sync[i] & ~last[i];
        end
    end

    // Two stages against metastability, a third for edges
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            meta   <= '0;
            sync   <= '0;
            last   <= '0;
            rise_o <= '0;
        end else begin
            meta   <= pin_i;
            sync   <= meta;
            last   <= sync;
            rise_o <= next_rise;
        end
    end

    assign level_o = sync;

endmodule

// [core/lmm_pkg.sv]
package lmm_pkg;

    // ------------------------------------------------------------
    // Clock and internal test clock timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_HZ    = 10_000_000;
    localparam int INT_CLK_HZ    = 10_000;
    localparam int INT_HALF_CYC  = SYS_CLK_HZ / (2 * INT_CLK_HZ);
    localparam int DIV_W         = 10;
    localparam logic [DIV_W-1:0] DIV_LAST =
        DIV_W'(INT_HALF_CYC - 1);

    // ------------------------------------------------------------
    // Register map, bit positions and reset values
    // ------------------------------------------------------------
    localparam int         AXI_AW       = 4;
    localparam logic [3:0] ADDR_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_STEP    = 4'h4;
    localparam logic [3:0] ADDR_STATUS  = 4'h8;
    localparam int         CTRL_LOOP_BIT = 0;
    localparam int         CTRL_RUN_BIT  = 1;
    localparam int         STEP_BIT      = 0;
    localparam logic [1:0] CTRL_RESET    = 2'h0;
    localparam int         STAT_MODE_LSB = 0;
    localparam int         STAT_SEND_BIT = 2;
    localparam int         STAT_RTS_BIT  = 3;
    localparam int         STAT_DTR_BIT  = 4;
    localparam int         STAT_VAR_BIT  = 5;
    localparam int         STAT_ICLK_BIT = 6;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

    // ------------------------------------------------------------
    // Pin inputs that cross into the system clock domain
    // ------------------------------------------------------------
    localparam int PIN_LINE_RX   = 0;
    localparam int PIN_CTS       = 1;
    localparam int PIN_MTX_CLK   = 2;
    localparam int PIN_MRX_CLK   = 3;
    localparam int PIN_INTEG_CLK = 4;
    localparam int PIN_VARIANT   = 5;
    localparam int NUM_PINS      = 6;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LMM_NORMAL,
        LMM_INT_MAINT,
        LMM_SYS_TEST,
        LMM_EXT_MAINT
    } lmm_mode_t;

    // Signals toward transmitter, receiver and modem
    typedef struct packed {
        logic send_enable;
        logic rts;
        logic dtr;
        logic rx_data;
        logic tx_bit_en;
        logic rx_bit_en;
        logic ext_clk;
    } lmm_line_t;

    // Mode from loop select and run state flag
    function automatic lmm_mode_t lmm_decode_mode(input logic loop_select,
                                                  input logic run_state_flag);
        lmm_mode_t m;
        m = LMM_NORMAL;
        unique case ({loop_select, run_state_flag})
            2'h0: m = LMM_NORMAL;
            2'h2: m = LMM_INT_MAINT;
            2'h3: m = LMM_SYS_TEST;
            2'h1: m = LMM_EXT_MAINT;
        endcase
        return m;
    endfunction

endpackage

// [verif/lmm_modem_model.sv]
module lmm_modem_model #(
    parameter int MCLK_HALF = 200,
    parameter int ICLK_HALF = 125
) (
    input  wire logic clk_sys_i,
    input  wire logic plug_i,
    input  wire logic ext_clk_i,
    input  wire logic rx_bit_i,
    input  wire logic cts_i,
    input  wire logic integral_i,
    output logic      line_rx_data_o,
    output logic      clear_to_send_o,
    output logic      modem_tx_clk_o,
    output logic      modem_rx_clk_o,
    output logic      integ_clk_o,
    output logic      variant_integral_o
);
    timeunit 1ns;
    timeprecision 1ns;

    int   mcnt = 0;
    int   icnt = 0;
    logic mclk = 1'h0;
    logic iclk = 1'h0;

    // Synchronous modems run their clocks free, never only in frames
    always @(posedge clk_sys_i) begin
        mcnt <= (mcnt == MCLK_HALF - 1) ? 0 : mcnt + 1;
        icnt <= (icnt == ICLK_HALF - 1) ? 0 : icnt + 1;
        if (mcnt == MCLK_HALF - 1) mclk <= ~mclk;
        if (icnt == ICLK_HALF - 1) iclk <= ~iclk;
    end

    assign modem_tx_clk_o     = plug_i ? ext_clk_i : mclk;
    assign modem_rx_clk_o     = plug_i ? ext_clk_i : mclk;
    assign integ_clk_o        = iclk;
    assign variant_integral_o = integral_i;
    // line data and clear to send
    assign line_rx_data_o     = rx_bit_i;
    assign clear_to_send_o    = cts_i;
endmodule

// [verif/tb_lmm_mode_select.sv]
module tb_lmm_mode_select
    import lmm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_sys_i = 1'h0;
    logic        rst_n_i   = 1'h0;
    logic [3:0]  awaddr    = 4'h0;
    logic [3:0]  araddr    = 4'h0;
    logic [3:0]  strb      = 4'h0;
    logic [31:0] wdata     = 32'h0;
    logic        awvalid   = 1'h0;
    logic        wvalid    = 1'h0;
    logic        bready    = 1'h0;
    logic        arvalid   = 1'h0;
    logic        rready    = 1'h0;
    logic        tx_d      = 1'h0;
    logic        rts_q     = 1'h0;
    logic        dtr_q     = 1'h0;
    logic        rx_b      = 1'h0;
    logic        cts_b     = 1'h0;
    logic        plug      = 1'h0;
    logic        integ     = 1'h0;
    logic        cnt_on    = 1'h0;
    logic        ext_q     = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        rx_pin, cts_pin, mtx, mrx, iclk, var_pin;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata, d, v;
    logic [3:0]  e;
    lmm_line_t   line;
    logic [31:0] seed       = 32'hb2651c67;
    int          fail_count = 0;
    int          tests_run  = 0;
    int          n_tx, n_rx, n_ext;

    always #50 clk_sys_i = ~clk_sys_i;

    lmm_mode_select i_lmm_mode_select (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_data_i(tx_d),
        .rts_req_i(rts_q), .dtr_req_i(dtr_q), .line_rx_data_i(rx_pin),
        .clear_to_send_i(cts_pin), .modem_tx_clk_i(mtx),
        .modem_rx_clk_i(mrx), .integ_clk_i(iclk),
        .variant_integral_i(var_pin), .line_o(line));

    lmm_modem_model i_lmm_modem_model (
        .clk_sys_i(clk_sys_i), .plug_i(plug), .ext_clk_i(line.ext_clk),
        .rx_bit_i(rx_b), .cts_i(cts_b), .integral_i(integ),
        .line_rx_data_o(rx_pin), .clear_to_send_o(cts_pin),
        .modem_tx_clk_o(mtx), .modem_rx_clk_o(mrx), .integ_clk_o(iclk),
        .variant_integral_o(var_pin));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Send, rts, dtr, rx for a mode; internal maintenance and system test modes loop and force send
    function automatic logic [3:0] exp_line(input logic [1:0] m);
        if (m == 2'h1 || m == 2'h2) return {1'h1, 1'h0, 1'h0, tx_d};
        return {cts_b, rts_q, dtr_q, rx_b};
    endfunction

    task automatic check(input string nm, input logic [31:0] x,
                         input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    // Readies are registers, so the negedge value is the one sampled next
    task automatic wr(input logic [3:0] a, input logic [31:0] dd,
                      input logic [3:0] s, output logic [1:0] rr);
        logic pa, pw, ta, tw;
        pa = 1'h1;
        pw = 1'h1;
        @(posedge clk_sys_i);
        awaddr  <= a;
        wdata   <= dd;
        strb    <= s;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        while (pa || pw) begin
            @(negedge clk_sys_i);
            ta = pa && awready;
            tw = pw && wready;
            @(posedge clk_sys_i);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        do @(negedge clk_sys_i); while (bvalid !== 1'h1);
        rr = bresp;
        @(posedge clk_sys_i);
        bready <= 1'h0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] dd,
                      output logic [1:0] rr);
        @(posedge clk_sys_i);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        do @(negedge clk_sys_i); while (arready !== 1'h1);
        @(posedge clk_sys_i);
        arvalid <= 1'h0;
        do @(negedge clk_sys_i); while (rvalid !== 1'h1);
        dd = rdata;
        rr = rresp;
        @(posedge clk_sys_i);
        rready <= 1'h0;
    endtask

    // Mode index to {run, loop}: a Gray code of the index
    task automatic set_mode(input logic [1:0] m);
        wr(ADDR_CTRL, {30'h0, m ^ {1'h0, m[1]}}, 4'hf, r);
        check("ctrl bresp", RESP_OKAY, r);
    endtask

    // Bit pulse counter sampled where outputs are settled
    always @(negedge clk_sys_i) begin
        if (!cnt_on) begin
            n_tx  = 0;
            n_rx  = 0;
            n_ext = 0;
        end else begin
            n_tx  += line.tx_bit_en;
            n_rx  += line.rx_bit_en;
            n_ext += (line.ext_clk && !ext_q);
        end
        ext_q = line.ext_clk;
    end

    // Window of 2000 cycles holds a whole number of every clock period
    task automatic win(input logic [1:0] m, input int eb, input int ee);
        set_mode(m);
        cyc(40);
        cnt_on <= 1'h1;
        if (m == 2'h1) repeat (3) wr(ADDR_STEP, 32'h1, 4'hf, r);
        cyc(2000);
        check("tx bit pulses", eb, n_tx);
        check("rx bit pulses", eb, n_rx);
        if (ee >= 0) check("ext clk rises", ee, n_ext);
        cnt_on <= 1'h0;
        $display("window mode %0d done", m);
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        cyc(5);
        @(negedge clk_sys_i);
        check("line in reset", 32'h0, {25'h0, line});
        check("readies", 32'h7, {29'h0, awready, wready, arready});
        @(posedge clk_sys_i);
        rst_n_i <= 1'h1;
        cyc(3);
        rd(ADDR_STATUS, d, r);
        check("reset mode", 32'h0, {30'h0, d[1:0]});
        rd(4'hc, d, r);
        check("unmapped rresp", RESP_SLVERR, r);
        wr(4'hc, 32'h3, 4'hf, r);
        check("unmapped bresp", RESP_SLVERR, r);
        wr(ADDR_STATUS, 32'h3, 4'hf, r);
        check("status wr bresp", RESP_OKAY, r);
        wr(ADDR_CTRL, 32'h1, 4'he, r);
        rd(ADDR_STATUS, d, r);
        check("mode kept", 32'h0, {30'h0, d[1:0]});
        rd(ADDR_STEP, d, r);
        check("step reads", 32'h0, d);
        $display("register map test done");
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_sys_i);
            v = rnd();
            tx_d  <= v[0];
            rts_q <= v[1];
            dtr_q <= v[2];
            rx_b  <= v[3];
            cts_b <= v[4];
            integ <= v[5];
            set_mode(v[9:8]);
            cyc(6);
            @(negedge clk_sys_i);
            e = exp_line(v[9:8]);
            check("levels", e, line[6:3]);
            rd(ADDR_STATUS, d, r);
            check("stat", {integ, e[1], e[2], e[3], v[9:8]}, d[5:0]);
        end
        $display("random mode test done");
        integ <= 1'h0;
        win(2'h0, 5, 0);
        win(2'h2, 2, 0);
        plug <= 1'h1;
        win(2'h3, 2, 2);
        plug  <= 1'h0;
        integ <= 1'h1;
        // Integral variant must leave the clock output still
        win(2'h3, 8, 0);
        win(2'h1, 3, 0);
        @(posedge clk_sys_i);
        rst_n_i <= 1'h0;
        cyc(3);
        rst_n_i <= 1'h1;
        cyc(3);
        rd(ADDR_STATUS, d, r);
        check("mode after reset", 32'h0, {30'h0, d[1:0]});
        $display("second reset test done");
        end_sim();
    end

    // Hang guard, about six times the expected run
    initial begin
        cyc(60000);
        fail_count++;
        $display("[ERR] watchdog expected finish seen hang");
        end_sim();
    end
endmodule
